// File: rtl/pil_pkg.sv
// Constants, register map and carrier types for the port pin interrupt block
package pil_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PINS   = 8;
  localparam int unsigned VEC_W  = 5;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_IN    = 8'h00;
  localparam logic [7:0] IDX_OUT   = 8'h02;
  localparam logic [7:0] IDX_DIR   = 8'h04;
  localparam logic [7:0] IDX_REN   = 8'h06;
  localparam logic [7:0] IDX_SEL0  = 8'h0a;
  localparam logic [7:0] IDX_SEL1  = 8'h0c;
  localparam logic [7:0] IDX_IV    = 8'h0e;
  localparam logic [7:0] IDX_IV_H  = 8'h0f;
  localparam logic [7:0] IDX_SELC  = 8'h16;
  localparam logic [7:0] IDX_IES   = 8'h18;
  localparam logic [7:0] IDX_IE    = 8'h1a;
  localparam logic [7:0] IDX_IFG   = 8'h1c;
  localparam logic [7:0] IDX_PMCTL = 8'h20;

  localparam logic [7:0] ADDR_IN    = {IDX_IN[5:0], 2'b00};
  localparam logic [7:0] ADDR_OUT   = {IDX_OUT[5:0], 2'b00};
  localparam logic [7:0] ADDR_DIR   = {IDX_DIR[5:0], 2'b00};
  localparam logic [7:0] ADDR_REN   = {IDX_REN[5:0], 2'b00};
  localparam logic [7:0] ADDR_SEL0  = {IDX_SEL0[5:0], 2'b00};
  localparam logic [7:0] ADDR_SEL1  = {IDX_SEL1[5:0], 2'b00};
  localparam logic [7:0] ADDR_IV    = {IDX_IV[5:0], 2'b00};
  localparam logic [7:0] ADDR_IV_H  = {IDX_IV_H[5:0], 2'b00};
  localparam logic [7:0] ADDR_SELC  = {IDX_SELC[5:0], 2'b00};
  localparam logic [7:0] ADDR_IES   = {IDX_IES[5:0], 2'b00};
  localparam logic [7:0] ADDR_IE    = {IDX_IE[5:0], 2'b00};
  localparam logic [7:0] ADDR_IFG   = {IDX_IFG[5:0], 2'b00};
  localparam logic [7:0] ADDR_PMCTL = {IDX_PMCTL[5:0], 2'b00};

  // Field positions
  localparam int unsigned LOCK_BIT = 0;
  localparam int unsigned LANE_LO  = 0;

  // Reset values
  localparam logic [7:0] RST_CFG  = 8'h00;
  localparam logic [7:0] RST_IFG  = 8'h00;
  localparam logic [7:0] RST_OE_N = 8'hff;
  localparam logic       RST_LOCK = 1'b1;
  localparam logic [4:0] VEC_NONE = 5'h00;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] dir;
    logic [7:0] ren;
    logic [7:0] sel0;
    logic [7:0] sel1;
    logic [7:0] ies;
    logic [7:0] ie;
  } pil_cfg_s;

endpackage

// File: rtl/pil_sync2.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pil_sync2 #(
  parameter int unsigned W = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // The first stage is read by the second stage only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // pil_sync2

// File: rtl/pil_prio_enc.sv
// Fixed-priority encoder: bit 0 highest, vector 2*(n+1) or zero
`timescale 1ns/1ps
module pil_prio_enc
  import pil_pkg::*;
(
  input  wire logic [7:0] req,
  output logic      [4:0] vector,
  output logic      [7:0] onehot
);

  always_comb begin
    vector = VEC_NONE;
    onehot = 8'h00;
    // Walk downward so the lowest set bit is the last to win
    for (int i = 7; i >= 0; i--) begin
      if (req[i]) begin
        vector = {i[3:0] + 4'h1, 1'b0};
        onehot = 8'h01 << i;
      end
    end
  end

endmodule // pil_prio_enc

// File: rtl/pil_port_irq.sv
// Port pin interrupt logic with AXI4-Lite register access
//
// Operation
// [R1] Function-selected pins never raise interrupts
// [R2] Eight flags prioritised, bit 0 highest
// [R3] Vector reports highest enabled pending flag
// [R4] Vector is 0 idle, else 2*(n+1)
// [R5] Vector readable as word or bytes
// [R6] Selected edge sets the pending flag
// [R7] Request needs enable and global enable
// [R8] Software may set flags directly
// [R9] Only transitions set flags, never levels
// [R10] Later-set flags keep requesting
// [R11] Output, direction, pull writes may set flags
// [R12] Vector low-byte access clears top flag
// [R13] Edge select 0 rising, 1 falling
// [R14] Edge-select change may set flag
// [R15] Enable bit gates its flag
// [R16] Brown-out: pins hi-Z, inputs disabled
// [R17] Configuration reaches pins after lock clears
// [R18] Power-up clear: pins inputs, functions off
// [R19] Software configures, unlocks, clears, then enables
// [R20] Debug-shared port resets to hi-Z inputs
// [R21] Locked: configuration writes leave pins alone
// [R22] Locked: pending flags cannot be cleared; power-up clear still clears them
// [R23] Vector reads zero after reset
// [R24] Pin inputs synchronised before edge detect
// [R25] Hardware set beats software clear
`timescale 1ns/1ps
module pil_port_irq
  import pil_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [PINS-1:0]   pin_pad_in,
  output logic      [PINS-1:0]   pin_drive,
  output logic      [PINS-1:0]   pin_drive_oe_n,
  output logic      [PINS-1:0]   pin_pull_en,
  output logic      [PINS-1:0]   pin_pull_up,
  output logic      [PINS-1:0]   pin_schmitt_en,
  output logic      [PINS-1:0]   pin_func_low,
  output logic      [PINS-1:0]   pin_func_high,
  input  wire logic              global_irq_enable,
  input  wire logic              power_up_clear,
  output logic                   port_irq
);

  pil_cfg_s    cfg;
  logic [7:0]  pin_irq_pending;
  logic        pin_lock;
  logic [7:0]  in_sync;
  logic [7:0]  in_prev;
  logic [7:0]  in_eff;
  logic [7:0]  sel_any;
  logic [7:0]  active;
  logic [4:0]  port_irq_vector;
  logic [7:0]  top_onehot;

  logic [ADDR_W-1:0] aw_addr;
  logic [7:0]        w_byte;
  logic              w_lane0;
  logic              aw_full;
  logic              w_full;
  logic              next_aw_full;
  logic              next_w_full;
  logic              next_bvalid;
  logic              next_rvalid;
  logic              wr_fire;
  logic              ar_fire;
  logic              wr_lo;
  logic              iv_ack;
  logic [7:0]        edge_hit;
  logic [7:0]        ies_hit;
  logic [7:0]        ack_clr;
  logic [7:0]        next_pending;
  logic [DATA_W-1:0] rd_word;
  logic              rd_ok;

  // Pin inputs cross into the clock domain before any edge logic
  pil_sync2 #(
    .W (PINS)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (pin_pad_in),
    .sync_out (in_sync)   // [R24]
  );

  assign sel_any = cfg.sel0 | cfg.sel1;
  // With Schmitt inputs off the internal level reads low
  assign in_eff  = in_sync & pin_schmitt_en;   // [R16]
  assign active  = pin_irq_pending & cfg.ie & ~sel_any;   // [R1] [R3] [R15]

  pil_prio_enc u_enc (
    .req    (active),   // [R2]
    .vector (port_irq_vector),   // [R4]
    .onehot (top_onehot)
  );

  // AXI4-Lite write channel: address and data accepted in any order
  assign wr_fire = aw_full & w_full & ~s_axi_bvalid;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign wr_lo   = wr_fire & w_lane0;

  always_comb begin
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_bvalid  = s_axi_bvalid;
    next_rvalid  = s_axi_rvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (ar_fire) begin
      next_rvalid = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr       <= '0;
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
    end else begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      s_axi_awready <= ~next_aw_full & ~next_bvalid;
      s_axi_wready  <= ~next_w_full & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
      end
      // Registers are a byte wide; only lane 0 carries them
      if (s_axi_wvalid && s_axi_wready) begin
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[LANE_LO];
      end
      if (wr_fire) begin
        case (aw_addr)
          ADDR_OUT, ADDR_DIR, ADDR_REN, ADDR_SEL0, ADDR_SEL1, ADDR_IV, ADDR_IV_H,
          ADDR_SELC, ADDR_IES, ADDR_IE, ADDR_IFG, ADDR_PMCTL, ADDR_IN: begin
            s_axi_bresp <= RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Configuration registers; these only hold software intent
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= '{out: RST_CFG, dir: RST_CFG, ren: RST_CFG, sel0: RST_CFG,
               sel1: RST_CFG, ies: RST_CFG, ie: RST_CFG};
    end else if (power_up_clear) begin
      cfg.dir  <= RST_CFG;   // [R18]
      cfg.ren  <= RST_CFG;
      cfg.sel0 <= RST_CFG;
      cfg.sel1 <= RST_CFG;
      cfg.ie   <= RST_CFG;
    end else if (wr_lo) begin
      case (aw_addr)
        ADDR_OUT:  cfg.out  <= w_byte;
        ADDR_DIR:  cfg.dir  <= w_byte;
        ADDR_REN:  cfg.ren  <= w_byte;
        ADDR_SEL0: cfg.sel0 <= w_byte;
        ADDR_SEL1: cfg.sel1 <= w_byte;
        ADDR_SELC: begin
          // Flips both select bits in one step, no intermediate function
          cfg.sel0 <= cfg.sel0 ^ w_byte;
          cfg.sel1 <= cfg.sel1 ^ w_byte;
        end
        ADDR_IES:  cfg.ies  <= w_byte;
        ADDR_IE:   cfg.ie   <= w_byte;
        default: begin
        end
      endcase
    end
  end

  // Lock is set by reset only; software can merely release it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_lock <= RST_LOCK;   // [R16]
    end else if (wr_lo && aw_addr == ADDR_PMCTL) begin
      pin_lock <= pin_lock & w_byte[LOCK_BIT];
    end
  end

  // Pin-facing state follows the configuration only while unlocked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_drive      <= 8'h00;
      pin_drive_oe_n <= RST_OE_N;   // [R16] [R20]
      pin_pull_en    <= 8'h00;
      pin_pull_up    <= 8'h00;
      pin_schmitt_en <= 8'h00;   // [R16]
      pin_func_low   <= 8'h00;
      pin_func_high  <= 8'h00;
    end else if (!pin_lock) begin   // [R17] [R21]
      pin_drive      <= cfg.out;
      pin_drive_oe_n <= ~cfg.dir;   // [R18]
      pin_pull_en    <= cfg.ren & ~cfg.dir;
      pin_pull_up    <= cfg.out;
      pin_schmitt_en <= 8'hff;
      pin_func_low   <= cfg.sel0;
      pin_func_high  <= cfg.sel1;
    end
  end

  // Edge detection on the synchronised, buffer-gated level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_prev <= 8'h00;
    end else begin
      in_prev <= in_eff;
    end
  end

  // Output, direction or pull writes reach the pin and may return as an edge
  assign edge_hit = ((in_eff & ~in_prev & ~cfg.ies) |
                     (~in_eff & in_prev & cfg.ies)) & ~sel_any;   // [R6] [R9] [R13] [R11]

  // Changing the edge select against the present level looks like an edge
  always_comb begin
    ies_hit = 8'h00;
    if (wr_lo && aw_addr == ADDR_IES) begin
      ies_hit = ((~cfg.ies & w_byte & ~in_eff) |
                 (cfg.ies & ~w_byte & in_eff)) & ~sel_any;   // [R14]
    end
  end

  // A read of the vector low byte, or a write touching its low byte, acknowledges
  assign iv_ack  = (wr_lo && aw_addr == ADDR_IV) ||
                   (ar_fire && s_axi_araddr == ADDR_IV);   // [R12]
  assign ack_clr = (iv_ack && !pin_lock) ? top_onehot : 8'h00;   // [R12] [R22]

  always_comb begin
    next_pending = pin_irq_pending;
    if (wr_lo && aw_addr == ADDR_IFG) begin
      if (pin_lock) begin
        next_pending = pin_irq_pending | w_byte;   // [R22] [R8]
      end else begin
        next_pending = w_byte;   // [R8]
      end
    end
    next_pending = next_pending & ~ack_clr;
    // Sets are applied last so a same-cycle clear cannot lose an event
    next_pending = next_pending | edge_hit | ies_hit;   // [R25] [R10]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || power_up_clear) begin
      pin_irq_pending <= RST_IFG;
    end else begin
      pin_irq_pending <= next_pending;
    end
  end

  // One request per port; remaining flags keep it high after an acknowledge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_irq <= 1'b0;
    end else begin
      port_irq <= (|(next_pending & cfg.ie & ~sel_any)) & global_irq_enable;   // [R7] [R10]
    end
  end

  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      ADDR_IN:    rd_word[7:0] = in_eff;
      ADDR_OUT:   rd_word[7:0] = cfg.out;
      ADDR_DIR:   rd_word[7:0] = cfg.dir;
      ADDR_REN:   rd_word[7:0] = cfg.ren;
      ADDR_SEL0:  rd_word[7:0] = cfg.sel0;
      ADDR_SEL1:  rd_word[7:0] = cfg.sel1;
      ADDR_IV:    rd_word[4:0] = port_irq_vector;   // [R3] [R5] [R23]
      ADDR_IV_H:  rd_word      = '0;   // [R5]
      ADDR_SELC:  rd_word      = '0;
      ADDR_IES:   rd_word[7:0] = cfg.ies;
      ADDR_IE:    rd_word[7:0] = cfg.ie;
      ADDR_IFG:   rd_word[7:0] = pin_irq_pending;
      ADDR_PMCTL: rd_word[LOCK_BIT] = pin_lock;
      default:    rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_fire) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

endmodule // pil_port_irq

// File: test/pil_port_irq_monitor.sv
// Bus and pin checker for the port pin interrupt block
`timescale 1ns/1ps
module pil_port_irq_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  pin_drive_oe_n,
  input wire logic [7:0]  pin_schmitt_en,
  input wire logic [7:0]  pin_func_low,
  input wire logic        global_irq_enable,
  input wire logic        power_up_clear,
  input wire logic        port_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_reset_hiz;
    $rose(aresetn) |-> pin_drive_oe_n == 8'hff && pin_schmitt_en == 8'h00 && pin_func_low == 8'h00;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz) else $error("pins not safe after reset");
  // Schmitt off means still locked, so pins must sit in the reset state
  property p_locked_hiz;
    pin_schmitt_en == 8'h00 |-> pin_drive_oe_n == 8'hff && pin_func_low == 8'h00;
  endproperty
  a_locked_hiz: assert property (p_locked_hiz) else $error("locked pins driven");
  property p_puc;
    power_up_clear |-> ##2 (pin_func_low == 8'h00 && !port_irq);
  endproperty
  a_puc: assert property (p_puc) else $error("power-up clear incomplete");
  property p_gie;
    !global_irq_enable |=> !port_irq;
  endproperty
  a_gie: assert property (p_gie) else $error("request without global enable");
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("write response dropped");
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("read data not held");
  property p_r_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_refuse: assert property (p_r_refuse) else $error("read taken while busy");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  cover property ($rose(port_irq));
  cover property ($rose(pin_schmitt_en[0]));
  cover property (power_up_clear);
endmodule // pil_port_irq_monitor

bind pil_port_irq pil_port_irq_monitor pil_port_irq_monitor_i (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .pin_drive_oe_n, .pin_schmitt_en,
  .pin_func_low, .global_irq_enable, .power_up_clear, .port_irq
);

// File: test/tb.sv
// Self-checking bench for the port pin interrupt block
`timescale 1ns/1ps
module tb;
  import pil_pkg::*;
  logic              aclk, aresetn, global_irq_enable, power_up_clear, port_irq;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]        s_axi_awprot, s_axi_arprot;
  logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rs;
  logic [PINS-1:0]   pin_pad_in, pin_drive_oe_n, pin_schmitt_en, pin_func_low;
  logic [PINS-1:0]   pin_drive, pin_pull_en, pin_pull_up, pin_func_high;
  int                num_errors = 0, checks = 0, seed = 32'hb11b4d4b;
  int                m_ifg, m_ie, m_sel, v;

  pil_port_irq pil_port_irq_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pin_pad_in, .pin_drive, .pin_drive_oe_n, .pin_pull_en, .pin_pull_up,
    .pin_schmitt_en, .pin_func_low, .pin_func_high, .global_irq_enable,
    .power_up_clear, .port_irq
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic late(input int n);
    if (n >= 50) begin
      num_errors++;
      summarize();
    end
  endtask

  // Ready is raised only after the response shows, so the slave must hold it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    late(n);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    chk(s_axi_bresp, RESP_OKAY);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    late(n);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Reference vector: lowest enabled, unselected pending pin wins
  function automatic int vec();
    for (int i = 0; i < 8; i++) begin
      if (m_ifg[i] && m_ie[i] && !m_sel[i]) return 2 * (i + 1);
    end
    return 0;
  endfunction

  initial begin
    {aresetn, global_irq_enable, power_up_clear, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pin_pad_in} = '0;
    s_axi_wstrb = 4'h1;
    m_ifg = 0;
    m_ie = 0;
    m_sel = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(pin_drive_oe_n, 8'hff);
    chk(pin_schmitt_en, 8'h00);
    rdr(ADDR_IV);
    chk(rd, 0);
    wr(ADDR_DIR, 8'h0f);
    wr(ADDR_OUT, 8'ha5);
    wr(ADDR_REN, 8'hff);
    repeat (3) @(posedge aclk);
    chk(pin_drive_oe_n, 8'hff);
    chk(pin_drive, 8'h00);
    wr(ADDR_IFG, 8'h01);
    wr(ADDR_IFG, 8'h00);
    wr(ADDR_IE, 8'h01);
    rdr(ADDR_IV);
    chk(rd, 2);
    rdr(ADDR_IFG);
    chk(rd, 1);
    rdr(8'hfc);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    chk(rd, 32'h0);
    wr(ADDR_PMCTL, 8'h00);
    repeat (2) @(posedge aclk);
    chk({pin_schmitt_en, pin_drive_oe_n}, 16'hfff0);
    chk({pin_drive, pin_pull_en, pin_pull_up}, 24'ha5f0a5);
    wr(ADDR_IE, 8'h00);
    wr(ADDR_IFG, 8'h00);
    wr(ADDR_IES, 8'h01);
    rdr(ADDR_IFG);
    chk(rd, 1);
    wr(ADDR_IFG, 8'h00);
    wr(ADDR_IES, 8'h00);
    rdr(ADDR_IFG);
    chk(rd, 0);
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_IES, e ? 8'hff : 8'h00);
      pin_pad_in <= e ? 8'hff : 8'h00;
      repeat (5) @(posedge aclk);
      wr(ADDR_IFG, 8'h00);
      m_ifg = 0;
      for (int n = 0; n < 8; n++) begin
        pin_pad_in[n] <= (e == 0);
        repeat (5) @(posedge aclk);
        m_ifg |= 1 << n;
        rdr(ADDR_IFG);
        chk(rd, m_ifg);
      end
      wr(ADDR_IFG, 8'h00);
      repeat (10) @(posedge aclk);
      rdr(ADDR_IFG);
      chk(rd, 0);
      pin_pad_in <= e ? 8'hff : 8'h00;
      repeat (5) @(posedge aclk);
      rdr(ADDR_IFG);
      chk(rd, 0);
    end
    // Random enable masks; odd rounds acknowledge by writing the vector
    for (int k = 0; k < 6; k++) begin
      global_irq_enable <= (k != 5);
      m_ie = $random(seed) & 255;
      m_sel = (k == 0);
      m_ifg = 255;
      wr(ADDR_IE, m_ie[7:0]);
      wr(ADDR_SEL0, m_sel[7:0]);
      wr(ADDR_IFG, 8'hff);
      repeat (2) @(posedge aclk);
      chk(port_irq, ((m_ifg & m_ie & ~m_sel) != 0) && k != 5);
      rdr(ADDR_IV_H);
      chk(rd, 0);
      for (int j = 0; j < 9; j++) begin
        v = vec();
        if (k % 2) wr(ADDR_IV, 8'h00);
        else rdr(ADDR_IV);
        if (k % 2 == 0) chk(rd, v);
        if (v != 0) m_ifg &= ~(1 << (v / 2 - 1));
        rdr(ADDR_IFG);
        chk(rd, m_ifg);
      end
    end
    // A write without lane 0 must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(ADDR_IE, ~m_ie[7:0]);
    s_axi_wstrb <= 4'h1;
    rdr(ADDR_IE);
    chk(rd, m_ie);
    wr(ADDR_SELC, 8'h3c);
    rdr(ADDR_SEL1);
    chk(rd, 8'h3c);
    chk(pin_func_high, 8'h3c);
    power_up_clear <= 1'b1;
    @(posedge aclk);
    power_up_clear <= 1'b0;
    repeat (3) @(posedge aclk);
    rdr(ADDR_IFG);
    chk(rd, 0);
    rdr(ADDR_DIR);
    chk(rd, 0);
    chk(pin_func_high, 8'h00);
    chk(pin_drive_oe_n, 8'hff);
    summarize();
  end
endmodule // tb
